// File: rifmu_cfg.svh
// Purpose: constants of the radio interrupt flag and mask unit
// Assumes: 100 MHz system clock
// Notes: times are kept in microseconds, cycle counts derive from them
`ifndef RIFMU_CFG_SVH
`define RIFMU_CFG_SVH

// ==========================================================
// clock and serial bus
`define RIFMU_CLK_MHZ 100
`define RIFMU_DEV_ADDR 7'h11
`define RIFMU_POS_FLAG 8'h00
`define RIFMU_POS_MASK 8'h01
`define RIFMU_POS_LATEST_LOW 8'h0F
`define RIFMU_POS_PREV_LOW 8'h11
`define RIFMU_POS_MASK_WR 8'h00

// ==========================================================
// bit positions, shared by flag byte and mask byte
`define RIFMU_BIT_DAV 7
`define RIFMU_BIT_PROBE 6
`define RIFMU_BIT_SYNC 5
`define RIFMU_BIT_IF 4
`define RIFMU_BIT_LEV 3
`define RIFMU_BIT_PAUSE 2
`define RIFMU_BIT_READY 1
`define RIFMU_BIT_BAND 0

// ==========================================================
// reset values and byte masks
`define RIFMU_FLAG_RESET 8'h00
`define RIFMU_MASK_RESET 8'h00
`define RIFMU_MASK_KEEP 8'h20
`define RIFMU_MASK_WR_BITS 8'hBF
`define RIFMU_FLAG_STORE_BITS 8'hBF

// ==========================================================
// timing
`define RIFMU_IF_START_US 15000
`define RIFMU_IF_RESULT_US 30600
`define RIFMU_PAUSE_GUARD_US 500
`define RIFMU_TLOW_MAX_US 1000
`define RIFMU_IF_START_CYC (`RIFMU_IF_START_US * `RIFMU_CLK_MHZ)
`define RIFMU_IF_RESULT_CYC (`RIFMU_IF_RESULT_US * `RIFMU_CLK_MHZ)
`define RIFMU_PAUSE_GUARD_CYC (`RIFMU_PAUSE_GUARD_US * `RIFMU_CLK_MHZ)
`define RIFMU_TLOW_MAX_CYC (`RIFMU_TLOW_MAX_US * `RIFMU_CLK_MHZ)

`endif

// File: rifmu_pkg.sv
// Purpose: types of the radio interrupt flag and mask unit
// Assumes: nothing
// Notes: constants live in rifmu_cfg.svh
`default_nettype none
package rifmu_pkg;

  // ==========================================================
  // serial bus slave states
  typedef enum logic [6:0] {
    st_idle = 7'h01,
    st_addr = 7'h02,
    st_addr_ack = 7'h04,
    st_tx = 7'h08,
    st_tx_ack = 7'h10,
    st_rx = 7'h20,
    st_rx_ack = 7'h40
  } rifmu_state_type;

  // ==========================================================
  // data available modes
  typedef enum logic [1:0] {
    dav_block_each_mode = 2'h0,
    dav_fast_pi_mode = 2'h1,
    dav_block_pair_mode = 2'h2
  } rifmu_dav_mode_type;

endpackage
`default_nettype wire

// File: rifmu_pulse_if.sv
// Purpose: link between the flag logic and the interrupt one-shot
// Assumes: both ends on sys_clk
// Notes: trigger, rearm and cut are single-cycle strobes
`timescale 1ns/1ns
`default_nettype none
interface rifmu_pulse_if;
  logic trigger;
  logic rearm;
  logic cut;
  logic active;
  modport ctrl (output trigger, output rearm, output cut, input active);
  modport shot (input trigger, input rearm, input cut, output active);
endinterface
`default_nettype wire

// File: rifmu_oneshot.sv
// Purpose: one-shot that times the low period of the interrupt line
// Assumes: strobes come from logic on sys_clk
// Notes: after firing it stays blocked until rearmed
`timescale 1ns/1ns
`default_nettype none
module rifmu_oneshot
#(
  parameter int TLOW_CYCLES = 100000
)
(
  input wire logic sys_clk,
  input wire logic reset_n,
  rifmu_pulse_if.shot pulse
);

  localparam int CW = $clog2(TLOW_CYCLES + 1);

  logic armed_reg;
  logic active_reg;
  logic [CW-1:0] count_reg;

  assign pulse.active = active_reg;

  // ==========================================================
  // pulse timing
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      armed_reg <= 1'h1;
      active_reg <= 1'h0;
      count_reg <= '0;
    end
    else
    begin
      if (pulse.rearm)
        armed_reg <= 1'h1;
      if (active_reg)
      begin
        count_reg <= count_reg + CW'(1);
        if (pulse.cut || count_reg == CW'(TLOW_CYCLES - 1))
          active_reg <= 1'h0;
      end
      else if (pulse.trigger && armed_reg)
      begin
        active_reg <= 1'h1;
        armed_reg <= 1'h0;
        count_reg <= '0;
      end
    end
  end

endmodule
`default_nettype wire

// File: rifmu_unit.sv
// Purpose: interrupt flag and mask unit of an FM/RDS receiver
// Assumes: host is the serial bus master; events are sys_clk pulses
// Notes: bus pins are sampled with three flops
//
// Functional notes
// - a read returns flag byte first, then mask byte.
// - flags active high; bits dav, probe, sync, if, level, pause, ready, band.
// - interrupt only for flags whose mask bit at same position is 1.
// - reading both bytes clears all masks except sync-loss mask.
// - sync-loss mask changes only by a host write.
// - flags and masks clear on read and on reset.
// - events during an interrupt-byte read wait until clearing is done.
// - window opens at read bit, closes at second ack or stop.
// - flag-only read then stop clears flags, leaves masks.
// - line low at most its maximum, ends early on flag and mask read.
// - repeated event on a set flag gives no new interrupt.
// - one-shot blocks after firing until mask read then written.
// - events during the low period do not extend it.
// - mask write enabling a set flag fires the line at once.
// - reading latest or previous block low byte clears data available.
// - data available set by sync found, fast PI block, or synced blocks.
// - sync loss with mask set raises flag and idles RDS section.
// - sync loss with mask clear restarts search and sets data available.
// - sync-loss flag cleared by mask byte read.
// - IF error flag set on bad IF count during tuning.
// - continuous IF counting starts 15 ms after tuning ready.
// - IF result reflects original channel 30.6 ms after tuning.
// - IF error flag cleared by mask read or tuning start.
// - tuning ready set at tuning end, cleared by mask read.
// - band limit set on band end or no lock, cleared by mask read.
// - level flag cleared by mask read or tuning start.
// - pause flag clears on read only 500 us after it was raised.
`include "rifmu_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module rifmu_unit
  import rifmu_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = `RIFMU_DEV_ADDR,
  parameter int IF_START_CYCLES = `RIFMU_IF_START_CYC,
  parameter int IF_RESULT_CYCLES = `RIFMU_IF_RESULT_CYC,
  parameter int PAUSE_GUARD_CYCLES = `RIFMU_PAUSE_GUARD_CYC,
  parameter int TLOW_CYCLES = `RIFMU_TLOW_MAX_CYC
)
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic scl_pin,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic interrupt_line_n_out,
  output logic interrupt_line_n_oe,
  input wire logic factory_probe_bit,
  input wire logic ev_if_error,
  input wire logic ev_level,
  input wire logic ev_pause,
  input wire logic ev_tune_start,
  input wire logic ev_tune_done,
  input wire logic ev_band_limit,
  input wire logic rds_block_done,
  input wire logic rds_sync_found,
  input wire logic rds_pi_block,
  input wire logic rds_sync_lost,
  input wire rifmu_dav_mode_type dav_mode,
  input wire logic new_sync_search_bit,
  input wire logic [7:0] ext_read_byte,
  output logic [7:0] read_position,
  output logic rds_idle,
  output logic rds_restart,
  output logic if_count_run,
  output logic if_result_current
);

  localparam int IW = $clog2(IF_RESULT_CYCLES + 1);
  localparam int PW = $clog2(PAUSE_GUARD_CYCLES + 1);

  logic [2:0] scl_sync_reg;
  logic [2:0] sda_sync_reg;
  logic scl_st_reg;
  logic sda_st_reg;
  logic scl_prev_reg;
  logic sda_prev_reg;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  rifmu_state_type state_reg;
  logic [2:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [1:0] phase_reg;
  logic is_read_reg;
  logic acked_reg;
  logic sda_oe_reg;
  logic [7:0] rd_ptr_reg;
  logic [7:0] wr_ptr_reg;
  logic [7:0] flag_reg;
  logic [7:0] flag_next;
  logic [7:0] pending_reg;
  logic [7:0] pending_next;
  logic [7:0] mask_reg;
  logic [7:0] act_prev_reg;
  logic [7:0] active_vec;
  logic [7:0] ev_vec;
  logic [7:0] clr_vec;
  logic [7:0] keep_vec;
  logic window_reg;
  logic flag_seen_reg;
  logic mask_seen_reg;
  logic window_open;
  logic byte_read_done;
  logic close_b1;
  logic close_b2;
  logic close_any;
  logic mask_write;
  logic [7:0] mask_wdata;
  logic sync_enable;
  logic synced_reg;
  logic pair_half_reg;
  logic rds_idle_reg;
  logic rds_restart_reg;
  logic dav_event;
  logic sync_event;
  logic [PW-1:0] pause_age_reg;
  logic pause_clearable;
  logic [IW-1:0] if_age_reg;
  logic if_timing_reg;
  logic if_run_reg;
  logic if_current_reg;
  logic sda_low_reg;
  logic line_low_reg;
  logic [7:0] tx_byte;
  rifmu_pulse_if pulse ();

  // ==========================================================
  // byte presented at a read position
  function automatic logic [7:0] rd_byte(input logic [7:0] pos);
    logic [7:0] b;
    b = ext_read_byte;
    if (pos == `RIFMU_POS_FLAG)
      b = {flag_reg[7], factory_probe_bit, flag_reg[5:0]};
    else if (pos == `RIFMU_POS_MASK)
      b = mask_reg & `RIFMU_MASK_WR_BITS;
    return b;
  endfunction

  always_comb tx_byte = rd_byte(rd_ptr_reg);

  // ==========================================================
  // pin sampling
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      scl_sync_reg <= 3'h7;
      sda_sync_reg <= 3'h7;
      scl_st_reg <= 1'h1;
      sda_st_reg <= 1'h1;
      scl_prev_reg <= 1'h1;
      sda_prev_reg <= 1'h1;
    end
    else
    begin
      scl_sync_reg <= {scl_sync_reg[1:0], scl_pin};
      sda_sync_reg <= {sda_sync_reg[1:0], sda_in};
      if (scl_sync_reg[1] == scl_sync_reg[2])
        scl_st_reg <= scl_sync_reg[2];
      if (sda_sync_reg[1] == sda_sync_reg[2])
        sda_st_reg <= sda_sync_reg[2];
      scl_prev_reg <= scl_st_reg;
      sda_prev_reg <= sda_st_reg;
    end
  end

  assign scl_rise = scl_st_reg && !scl_prev_reg;
  assign scl_fall = !scl_st_reg && scl_prev_reg;
  assign bus_start = scl_st_reg && scl_prev_reg && sda_prev_reg && !sda_st_reg;
  assign bus_stop = scl_st_reg && scl_prev_reg && !sda_prev_reg && sda_st_reg;

  // ==========================================================
  // serial bus slave
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      state_reg <= st_idle;
      bit_cnt_reg <= 3'h0;
      shift_reg <= 8'h00;
      phase_reg <= 2'h0;
      is_read_reg <= 1'h0;
      acked_reg <= 1'h0;
      sda_oe_reg <= 1'h0;
      rd_ptr_reg <= 8'h00;
      wr_ptr_reg <= 8'h00;
    end
    else if (bus_start)
    begin
      state_reg <= st_addr;
      bit_cnt_reg <= 3'h0;
      sda_oe_reg <= 1'h0;
    end
    else if (bus_stop)
    begin
      state_reg <= st_idle;
      sda_oe_reg <= 1'h0;
    end
    else
    begin
      unique case (state_reg)
        st_idle:
        begin
          sda_oe_reg <= 1'h0;
        end
        st_addr:
        begin
          if (scl_rise)
          begin
            shift_reg <= {shift_reg[6:0], sda_st_reg};
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            if (bit_cnt_reg == 3'h7)
            begin
              phase_reg <= 2'h0;
              is_read_reg <= sda_st_reg;
              rd_ptr_reg <= `RIFMU_POS_FLAG;
              wr_ptr_reg <= `RIFMU_POS_MASK_WR;
              state_reg <= (shift_reg[6:0] == DEV_ADDR) ? st_addr_ack : st_idle;
            end
          end
        end
        st_addr_ack:
        begin
          if (scl_fall && phase_reg == 2'h0)
          begin
            sda_oe_reg <= 1'h1;
            phase_reg <= 2'h1;
          end
          else if (scl_fall)
          begin
            bit_cnt_reg <= 3'h0;
            if (is_read_reg)
            begin
              sda_oe_reg <= !tx_byte[7];
              shift_reg <= {tx_byte[6:0], 1'h0};
              state_reg <= st_tx;
            end
            else
            begin
              sda_oe_reg <= 1'h0;
              state_reg <= st_rx;
            end
          end
        end
        st_tx:
        begin
          if (scl_fall && bit_cnt_reg != 3'h0)
          begin
            sda_oe_reg <= !shift_reg[7];
            shift_reg <= {shift_reg[6:0], 1'h0};
          end
          if (scl_rise)
          begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            if (bit_cnt_reg == 3'h7)
            begin
              phase_reg <= 2'h0;
              state_reg <= st_tx_ack;
            end
          end
        end
        st_tx_ack:
        begin
          if (scl_fall && phase_reg == 2'h0)
          begin
            sda_oe_reg <= 1'h0;
            phase_reg <= 2'h1;
          end
          else if (scl_rise && phase_reg == 2'h1)
          begin
            acked_reg <= !sda_st_reg;
            rd_ptr_reg <= rd_ptr_reg + 8'h01;
            phase_reg <= 2'h2;
          end
          else if (scl_fall && phase_reg == 2'h2)
          begin
            bit_cnt_reg <= 3'h0;
            if (acked_reg)
            begin
              sda_oe_reg <= !tx_byte[7];
              shift_reg <= {tx_byte[6:0], 1'h0};
              state_reg <= st_tx;
            end
            else
              state_reg <= st_idle;
          end
        end
        st_rx:
        begin
          if (scl_rise)
          begin
            shift_reg <= {shift_reg[6:0], sda_st_reg};
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            if (bit_cnt_reg == 3'h7)
            begin
              phase_reg <= 2'h0;
              state_reg <= st_rx_ack;
            end
          end
        end
        st_rx_ack:
        begin
          if (scl_fall && phase_reg == 2'h0)
          begin
            sda_oe_reg <= 1'h1;
            phase_reg <= 2'h1;
          end
          else if (scl_fall)
          begin
            sda_oe_reg <= 1'h0;
            bit_cnt_reg <= 3'h0;
            wr_ptr_reg <= wr_ptr_reg + 8'h01;
            state_reg <= st_rx;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // read window and strobes
  assign window_open = state_reg == st_addr && scl_rise && bit_cnt_reg == 3'h7 &&
                       shift_reg[6:0] == DEV_ADDR && sda_st_reg;
  assign byte_read_done = state_reg == st_tx_ack && scl_rise && phase_reg == 2'h1;
  assign close_b2 = window_reg && byte_read_done && rd_ptr_reg == `RIFMU_POS_MASK;
  assign close_b1 = window_reg && flag_seen_reg && (bus_stop || bus_start);
  assign close_any = close_b2 || (window_reg && (bus_stop || bus_start));
  assign mask_write = state_reg == st_rx && scl_rise && bit_cnt_reg == 3'h7 &&
                      wr_ptr_reg == `RIFMU_POS_MASK_WR;
  assign mask_wdata = {shift_reg[6:0], sda_st_reg};

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      window_reg <= 1'h0;
      flag_seen_reg <= 1'h0;
      mask_seen_reg <= 1'h0;
    end
    else
    begin
      if (window_open)
        window_reg <= 1'h1;
      else if (close_any)
        window_reg <= 1'h0;
      if (close_any)
        flag_seen_reg <= 1'h0;
      else if (window_reg && byte_read_done && rd_ptr_reg == `RIFMU_POS_FLAG)
        flag_seen_reg <= 1'h1;
      if (close_b2)
        mask_seen_reg <= 1'h1;
      else if (mask_write)
        mask_seen_reg <= 1'h0;
    end
  end

  // ==========================================================
  // RDS synchronisation events
  assign sync_enable = mask_reg[`RIFMU_BIT_SYNC];
  assign dav_event = !rds_idle_reg &&
                     (rds_sync_found ||
                      (!synced_reg && dav_mode == dav_fast_pi_mode && rds_pi_block) ||
                      (synced_reg && rds_block_done &&
                       (dav_mode != dav_block_pair_mode || pair_half_reg)) ||
                      (synced_reg && rds_sync_lost && !sync_enable));
  assign sync_event = !rds_idle_reg && synced_reg && rds_sync_lost && sync_enable;

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      synced_reg <= 1'h0;
      pair_half_reg <= 1'h0;
      rds_idle_reg <= 1'h0;
      rds_restart_reg <= 1'h0;
    end
    else
    begin
      rds_restart_reg <= 1'h0;
      if (new_sync_search_bit && rds_idle_reg)
      begin
        rds_idle_reg <= 1'h0;
        rds_restart_reg <= 1'h1;
      end
      else if (synced_reg && rds_sync_lost && !rds_idle_reg)
      begin
        synced_reg <= 1'h0;
        rds_idle_reg <= sync_enable;
        rds_restart_reg <= !sync_enable;
      end
      else if (rds_sync_found && !rds_idle_reg)
      begin
        synced_reg <= 1'h1;
        pair_half_reg <= 1'h0;
      end
      else if (synced_reg && rds_block_done && dav_mode == dav_block_pair_mode)
        pair_half_reg <= !pair_half_reg;
    end
  end

  // ==========================================================
  // flags, pending events and masks
  always_comb
  begin
    ev_vec = 8'h00;
    ev_vec[`RIFMU_BIT_DAV] = dav_event;
    ev_vec[`RIFMU_BIT_SYNC] = sync_event;
    ev_vec[`RIFMU_BIT_IF] = ev_if_error;
    ev_vec[`RIFMU_BIT_LEV] = ev_level;
    ev_vec[`RIFMU_BIT_PAUSE] = ev_pause;
    ev_vec[`RIFMU_BIT_READY] = ev_tune_done;
    ev_vec[`RIFMU_BIT_BAND] = ev_band_limit;
    clr_vec = 8'h00;
    clr_vec[`RIFMU_BIT_IF] = ev_tune_start;
    clr_vec[`RIFMU_BIT_LEV] = ev_tune_start;
    clr_vec[`RIFMU_BIT_DAV] = byte_read_done &&
                              (rd_ptr_reg == `RIFMU_POS_LATEST_LOW ||
                               rd_ptr_reg == `RIFMU_POS_PREV_LOW);
    keep_vec = 8'h00;
    keep_vec[`RIFMU_BIT_PAUSE] = !pause_clearable;
    flag_next = flag_reg & ~clr_vec;
    pending_next = pending_reg;
    if (close_b1 || close_b2)
      flag_next = flag_next & keep_vec;
    if (close_any)
    begin
      flag_next = flag_next | pending_reg | ev_vec;
      pending_next = 8'h00;
    end
    else if (window_reg)
      pending_next = pending_reg | ev_vec;
    else
      flag_next = flag_next | ev_vec;
    flag_next = flag_next & `RIFMU_FLAG_STORE_BITS;
  end

  assign active_vec = flag_reg & mask_reg;

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      flag_reg <= `RIFMU_FLAG_RESET;
      pending_reg <= 8'h00;
      mask_reg <= `RIFMU_MASK_RESET;
      act_prev_reg <= 8'h00;
    end
    else
    begin
      flag_reg <= flag_next;
      pending_reg <= pending_next;
      act_prev_reg <= active_vec;
      if (close_b2)
        mask_reg <= mask_reg & `RIFMU_MASK_KEEP;
      else if (mask_write)
        mask_reg <= mask_wdata & `RIFMU_MASK_WR_BITS;
    end
  end

  // ==========================================================
  // pause clear guard
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      pause_age_reg <= '0;
    else if (ev_pause && !flag_reg[`RIFMU_BIT_PAUSE])
      pause_age_reg <= '0;
    else if (!pause_clearable)
      pause_age_reg <= pause_age_reg + PW'(1);
  end

  assign pause_clearable = pause_age_reg >= PW'(PAUSE_GUARD_CYCLES);

  // ==========================================================
  // IF counter timing after tuning
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      if_age_reg <= '0;
      if_timing_reg <= 1'h0;
      if_run_reg <= 1'h0;
      if_current_reg <= 1'h0;
    end
    else if (ev_tune_start)
    begin
      if_timing_reg <= 1'h0;
      if_run_reg <= 1'h0;
      if_current_reg <= 1'h0;
    end
    else if (ev_tune_done)
    begin
      if_age_reg <= '0;
      if_timing_reg <= 1'h1;
      if_run_reg <= 1'h0;
      if_current_reg <= 1'h0;
    end
    else if (if_timing_reg)
    begin
      if (if_age_reg != IW'(IF_RESULT_CYCLES))
        if_age_reg <= if_age_reg + IW'(1);
      if_run_reg <= if_age_reg >= IW'(IF_START_CYCLES);
      if_current_reg <= if_age_reg >= IW'(IF_RESULT_CYCLES);
    end
  end

  // ==========================================================
  // interrupt one-shot
  assign pulse.trigger = |(active_vec & ~act_prev_reg);
  assign pulse.rearm = mask_write && mask_seen_reg;
  assign pulse.cut = close_b2;

  rifmu_oneshot #(
    .TLOW_CYCLES(TLOW_CYCLES)
  ) u_oneshot (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .pulse(pulse)
  );

  always_ff @(posedge sys_clk)
  begin
    sda_low_reg <= 1'h0;
    line_low_reg <= 1'h0;
  end

  // ==========================================================
  // outputs
  assign sda_out = sda_low_reg;
  assign sda_oe = sda_oe_reg;
  assign interrupt_line_n_out = line_low_reg;
  assign interrupt_line_n_oe = pulse.active;
  assign read_position = rd_ptr_reg;
  assign rds_idle = rds_idle_reg;
  assign rds_restart = rds_restart_reg;
  assign if_count_run = if_run_reg;
  assign if_result_current = if_current_reg;

endmodule
`default_nettype wire

// File: rifmu_unit_checker.sv
// Purpose: port checker for rifmu_unit
// Assumes: one clock domain, synchronous reset
// Notes: attached by bind at the foot of this file
`timescale 1ns/1ns
`default_nettype none
module rifmu_unit_checker
#(
  parameter int TLOW_CYCLES = 100000,
  parameter int IF_START_CYCLES = 1500000
)
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic scl_pin,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic interrupt_line_n_out,
  input wire logic interrupt_line_n_oe,
  input wire logic ev_tune_start,
  input wire logic ev_tune_done,
  input wire logic rds_sync_lost,
  input wire logic new_sync_search_bit,
  input wire logic rds_idle,
  input wire logic if_count_run
);
  int low_cnt;
  int tune_cnt;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // ==========================================================
  // helper counters
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n || !interrupt_line_n_oe)
      low_cnt <= 0;
    else
      low_cnt <= low_cnt + 1;
  end
  // cycles since tuning finished, parked high when no timing runs
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n || ev_tune_start)
      tune_cnt <= 32'h7FFF0000;
    else if (ev_tune_done)
      tune_cnt <= 1;
    else if (tune_cnt < 32'h7FFF0000)
      tune_cnt <= tune_cnt + 1;
  end
  chk_reset_quiet: assert property ($rose(reset_n) |-> !interrupt_line_n_oe && !sda_oe && !rds_idle)
    else $error("outputs active after reset");
  chk_drive_low_only: assert property (!interrupt_line_n_out && !sda_out)
    else $error("pin driven high");
  chk_pulse_max: assert property (low_cnt <= TLOW_CYCLES)
    else $error("interrupt pulse too long");
  chk_early_release: assert property ($fell(interrupt_line_n_oe) |-> low_cnt >= TLOW_CYCLES - 1 || scl_pin)
    else $error("interrupt released without cause");
  chk_if_start: assert property ($rose(if_count_run) |-> tune_cnt >= IF_START_CYCLES && tune_cnt <= IF_START_CYCLES + 3)
    else $error("counting started at wrong time");
  chk_idle_hold: assert property (rds_idle && !new_sync_search_bit |=> rds_idle)
    else $error("idle left without new search");
  chk_idle_cause: assert property ($rose(rds_idle) |-> $past(rds_sync_lost) || $past(rds_sync_lost, 2))
    else $error("idle without sync loss");
  chk_sda_steady: assert property (scl_pin && $past(scl_pin) |-> $stable(sda_oe))
    else $error("data changed while clock high");
endmodule
bind rifmu_unit rifmu_unit_checker #(.TLOW_CYCLES(TLOW_CYCLES), .IF_START_CYCLES(IF_START_CYCLES)) u_checker
(
  .sys_clk(sys_clk), .reset_n(reset_n), .scl_pin(scl_pin), .sda_out(sda_out), .sda_oe(sda_oe),
  .interrupt_line_n_out(interrupt_line_n_out), .interrupt_line_n_oe(interrupt_line_n_oe),
  .ev_tune_start(ev_tune_start), .ev_tune_done(ev_tune_done), .rds_sync_lost(rds_sync_lost),
  .new_sync_search_bit(new_sync_search_bit), .rds_idle(rds_idle), .if_count_run(if_count_run)
);
`default_nettype wire

// File: rifmu_host_model.sv
// Purpose: host serial bus master model
// Assumes: 16 sys_clk cycles per bit
// Notes: a released data line goes to the pull-up
`timescale 1ns/1ns
`default_nettype none
module rifmu_host_model
(
  input wire logic sys_clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_pull
);
  logic [7:0] rbuf [0:17];
  logic nak = 1'b0;
  initial
  begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  // ==========================================================
  // bit and frame tasks
  task automatic hc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic bx(input logic b, output logic r);
    hc(4);
    sda_pull = !b;
    hc(4);
    scl = 1'b1;
    hc(4);
    r = sda_line;
    hc(4);
    scl = 1'b0;
  endtask
  task automatic xfer(input logic [7:0] a, input int n, input logic [7:0] w);
    logic [8:0] q;
    hc(8);
    sda_pull = 1'b1;
    hc(8);
    scl = 1'b0;
    for (int k = 8; k >= 0; k--) bx(k > 0 ? a[k - 1] : 1'b1, q[k]);
    nak = nak | q[0];
    for (int i = 0; i < n; i++)
    begin
      for (int k = 8; k >= 0; k--) bx(a[0] ? (k > 0 || i == n - 1) : (k > 0 ? w[k - 1] : 1'b1), q[k]);
      rbuf[i] = q[8:1];
      nak = nak | (q[0] & !a[0]);
    end
    hc(4);
    sda_pull = 1'b1;
    hc(4);
    scl = 1'b1;
    hc(8);
    sda_pull = 1'b0;
    hc(8);
  endtask
endmodule
`default_nettype wire

// File: radio_interrupt_flag_mask_unit_test.sv
// Purpose: self-checking bench for the interrupt flag and mask unit
// Assumes: shortened timing parameters
// Notes: expected bytes follow the flag and mask layout
`timescale 1ns/1ns
`default_nettype none
module radio_interrupt_flag_mask_unit_test;
  import rifmu_pkg::*;
  localparam int TLOW = 50;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic probe = 1'b0;
  logic [10:0] ev = 11'h000;
  logic scl, sda_pull, sda_oe, sda_out, int_oe, int_out, idle;
  wire logic sda;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;
  assign sda = !(sda_pull | sda_oe);
  rifmu_host_model host (.sys_clk(sys_clk), .sda_line(sda), .scl(scl), .sda_pull(sda_pull));
  rifmu_unit #(.IF_START_CYCLES(100), .IF_RESULT_CYCLES(204), .PAUSE_GUARD_CYCLES(40), .TLOW_CYCLES(TLOW)) DUT
  (
    .sys_clk(sys_clk), .reset_n(reset_n), .scl_pin(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .interrupt_line_n_out(int_out), .interrupt_line_n_oe(int_oe), .factory_probe_bit(probe),
    .ev_band_limit(ev[0]), .ev_tune_done(ev[1]), .ev_pause(ev[2]), .ev_level(ev[3]), .ev_if_error(ev[4]),
    .ev_tune_start(ev[5]), .rds_block_done(ev[6]), .rds_sync_found(ev[7]), .rds_pi_block(ev[8]),
    .rds_sync_lost(ev[9]), .new_sync_search_bit(ev[10]), .dav_mode(dav_block_each_mode), .ext_read_byte(8'h5A),
    .read_position(), .rds_idle(idle), .rds_restart(), .if_count_run(), .if_result_current()
  );
  initial forever #5 sys_clk = !sys_clk;
  // ==========================================================
  // access tasks
  task ck(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e)
    begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task pulse(input int i);
    ev = 11'h001 << i;
    host.hc(1);
    ev = 11'h000;
  endtask
  task rd(input logic [7:0] f, input logic [7:0] m);
    host.xfer(8'h23, 2, 8'h00);
    ck(host.rbuf[0], f);
    ck(host.rbuf[1], m);
  endtask
  task wr(input logic [7:0] m);
    host.xfer(8'h22, 1, m);
  endtask
  task wrap_up;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      failures++;
      $display("Error at %0t: timeout", $time);
      wrap_up;
    end
  end
  initial
  begin
    host.hc(4);
    reset_n = 1'b1;
    host.hc(4);
    rd(8'h00, 8'h00);
    for (int i = 0; i < 5; i++)
    begin
      wr(8'h40 | (8'h01 << i));
      pulse(i);
      host.hc(3);
      ck({7'h00, int_oe}, 8'h01);
      rd(8'h01 << i, 8'h01 << i);
      ck({7'h00, int_oe}, 8'h00);
    end
    $display("flag bit test done");
    wr(8'h03);
    pulse(0);
    host.hc(TLOW + 4);
    ck({7'h00, int_oe}, 8'h00);
    pulse(0);
    pulse(1);
    host.hc(4);
    ck({7'h00, int_oe}, 8'h00);
    rd(8'h03, 8'h03);
    pulse(3);
    wr(8'h08);
    ck({7'h00, int_oe}, 8'h01);
    rd(8'h08, 8'h08);
    fork
      rd(8'h00, 8'h00);
      begin
        host.hc(350);
        pulse(3);
      end
    join
    rd(8'h08, 8'h00);
    wr(8'h01);
    pulse(0);
    host.xfer(8'h23, 1, 8'h00);
    ck(host.rbuf[0], 8'h01);
    rd(8'h00, 8'h01);
    probe = 1'b1;
    wr(8'h20);
    rd(8'h40, 8'h20);
    probe = 1'b0;
    pulse(7);
    pulse(9);
    host.hc(3);
    ck({6'h00, idle, int_oe}, 8'h03);
    rd(8'hA0, 8'h20);
    pulse(10);
    wr(8'h00);
    pulse(7);
    pulse(9);
    host.hc(3);
    ck({6'h00, idle, int_oe}, 8'h00);
    rd(8'h80, 8'h00);
    $display("mask test done");
    for (int k = 3; k <= 16; k += 13)
    begin
      fork
        host.xfer(8'h23, k, 8'h00);
        begin
          host.hc(500);
          pulse(7);
        end
      join
      ck(host.rbuf[2], 8'h5A);
      rd(k == 3 ? 8'h80 : 8'h00, 8'h00);
    end
    ck({7'h00, host.nak}, 8'h00);
    host.xfer(8'h24, 1, 8'hFF);
    ck({7'h00, host.nak}, 8'h01);
    rd(8'h00, 8'h00);
    $display("data test done");
    wrap_up;
  end
endmodule
`default_nettype wire
